// File: test/pin_change_disable_enable_tb.sv
// Testbench: terminal end driving card end through the PIN command link
`timescale 1ns/100ps
module pin_change_disable_enable_tb;
   import pin_cmd_pkg::*;
   // ==========================================================
   // Signals
   logic        clock;          // 40 MHz clock
   logic        reset;          // Synchronous, active high
   logic        req_valid;      // User request pulse
   logic [7:0]  req_ins;        // Command
   logic [7:0]  req_p1;         // Option byte
   logic [7:0]  req_p2;         // PIN reference
   logic [63:0] req_pin;        // PIN or old PIN
   logic [63:0] req_new;        // New PIN
   logic        req_ready;      // Terminal idle
   logic        done;           // Status arrived
   logic [15:0] status;         // Last status word
   logic        multi_ref;      // File names several keys
   logic        access_ok;      // Access granted
   logic        alt_key_needed; // Replacement key active
   logic        busy;           // Card working
   logic [31:0] rand_state;     // Random generator state
   logic [63:0] cur_pin;        // PIN the card should hold
   int          mismatches;     // Failed comparisons
   int          total_checks;   // All comparisons
   // ==========================================================
   // Design under test: both ends joined by the link
   pin_link_if pin_link_if_i ();
   pin_card_end pin_card_end_i (.clock(clock), .reset(reset), .link(pin_link_if_i),
      .multi_ref(multi_ref), .access_ok(access_ok), .alt_key_needed(alt_key_needed),
      .busy(busy));
   pin_terminal_end pin_terminal_end_i (.clock(clock), .reset(reset), .req_valid(req_valid),
      .req_ins(req_ins), .req_p1(req_p1), .req_p2(req_p2), .req_pin(req_pin),
      .req_new(req_new), .req_ready(req_ready), .done(done), .status(status),
      .link(pin_link_if_i));
   pin_link_monitor pin_link_monitor_i (.clock(clock), .reset(reset),
      .cmd_valid(pin_link_if_i.cmd_valid), .ins(pin_link_if_i.ins), .p1(pin_link_if_i.p1),
      .p2(pin_link_if_i.p2), .lc(pin_link_if_i.lc), .data(pin_link_if_i.data),
      .rsp_valid(pin_link_if_i.rsp_valid), .sw(pin_link_if_i.sw), .busy(busy),
      .access_ok(access_ok), .alt_key_needed(alt_key_needed));
   // ==========================================================
   // Clock generator
   always #12.5 clock = ~clock;
   // ==========================================================
   // Helpers: random numbers and expected values
   function automatic logic [31:0] next_rand();
      rand_state = {rand_state[30:0],
                    rand_state[31] ^ rand_state[21] ^ rand_state[1] ^ rand_state[0]};
      return rand_state;
   endfunction
   // Wrong PIN: never equal, since the low word always flips
   function automatic logic [63:0] bad_pin();
      return cur_pin ^ {32'h0, next_rand() | 32'h1};
   endfunction
   // Random valid reference, either scope
   function automatic logic [7:0] any_p2();
      logic [31:0] r;
      r = next_rand();
      return {r[0], 2'b00, (r[5:1] == 5'h00) ? 5'h01 : r[5:1]};
   endfunction
   function automatic logic [15:0] wrong_sw(input logic [1:0] left);
      return SW_WRONG | {14'h0, left};
   endfunction
   // ==========================================================
   // Comparison, verdict, reset and command tasks
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Reset held 12 cycles, then a bounded wait for the terminal
   task automatic do_reset();
      int n;
      reset = 1'b1;
      repeat (12) @(negedge clock);
      reset = 1'b0;
      cur_pin = PIN_INIT;
      n = 0;
      while (req_ready !== 1'b1 && n < 20) begin
         @(negedge clock);
         n++;
      end
      if (n >= 20) begin
         mismatches++;
         finish_test();
      end
   endtask
   // One command through the terminal, status compared on done
   task automatic send(input logic [7:0] i, input logic [7:0] a, input logic [7:0] b,
                       input logic [63:0] pin, input logic [63:0] npin, input logic [15:0] exp);
      int n;
      req_ins = i;
      req_p1 = a;
      req_p2 = b;
      req_pin = pin;
      req_new = npin;
      req_valid = 1'b1;
      @(negedge clock);
      req_valid = 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 60) begin
         @(negedge clock);
         n++;
      end
      if (n >= 60) begin
         mismatches++;
         finish_test();
      end
      check(status, exp);
      @(negedge clock);
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      logic [63:0] npin; // Next PIN to store
      clock = 1'b0;
      reset = 1'b1;
      req_valid = 1'b0;
      req_ins = 8'h00;
      req_p1 = 8'h00;
      req_p2 = 8'h01;
      req_pin = 64'h0;
      req_new = 64'h0;
      multi_ref = 1'b0;
      rand_state = 32'h12e8;
      mismatches = 0;
      total_checks = 0;
      do_reset();
      // Malformed headers and an enable while enabled change nothing
      send(8'h20, 8'h00, any_p2(), cur_pin, 64'h0, SW_INS);
      send(INS_DISABLE, P1_RESERVED, any_p2(), cur_pin, 64'h0, SW_P1P2);
      send(INS_DISABLE, 8'h41, any_p2(), cur_pin, 64'h0, SW_P1P2);
      send(INS_DISABLE, 8'h80, any_p2(), cur_pin, 64'h0, SW_P1P2);
      send(INS_CHANGE, 8'h00, 8'h00, cur_pin, 64'h0, SW_P1P2);
      send(INS_CHANGE, 8'h00, 8'h21, cur_pin, 64'h0, SW_P1P2);
      send(INS_ENABLE, 8'h00, any_p2(), cur_pin, 64'h0, SW_STATE);
      // Change: wrong keeps PIN, right stores new and restores count
      npin = {next_rand(), next_rand()};
      send(INS_CHANGE, 8'h00, any_p2(), bad_pin(), npin, wrong_sw(2'h2));
      send(INS_CHANGE, 8'h00, any_p2(), cur_pin, npin, SW_OK);
      cur_pin = npin;
      send(INS_CHANGE, 8'h00, any_p2(), bad_pin(), npin, wrong_sw(2'h2));
      // Disable: count runs on across commands, then plain disable
      send(INS_DISABLE, 8'h00, any_p2(), bad_pin(), 64'h0, wrong_sw(2'h1));
      check({15'h0, access_ok}, 16'h0);
      send(INS_DISABLE, 8'h00, any_p2(), cur_pin, 64'h0, SW_OK);
      check({15'h0, access_ok}, 16'h1);
      send(INS_DISABLE, 8'h00, any_p2(), cur_pin, 64'h0, SW_STATE);
      send(INS_CHANGE, 8'h00, any_p2(), cur_pin, npin, SW_STATE);
      send(INS_ENABLE, 8'h00, any_p2(), bad_pin(), 64'h0, wrong_sw(2'h2));
      check({15'h0, access_ok}, 16'h1);
      send(INS_ENABLE, 8'h00, any_p2(), cur_pin, 64'h0, SW_OK);
      check({15'h0, access_ok}, 16'h0);
      // Disable with replacement key, then a multi-reference file
      send(INS_DISABLE, 8'h85, any_p2(), cur_pin, 64'h0, SW_OK);
      check({14'h0, alt_key_needed, access_ok}, 16'h2);
      multi_ref = 1'b1;
      repeat (3) @(negedge clock);
      check({15'h0, access_ok}, 16'h1);
      multi_ref = 1'b0;
      send(INS_ENABLE, 8'h00, any_p2(), cur_pin, 64'h0, SW_OK);
      check({14'h0, alt_key_needed, access_ok}, 16'h0);
      // Three wrong enables block the PIN and switch it on
      send(INS_DISABLE, 8'h00, any_p2(), cur_pin, 64'h0, SW_OK);
      send(INS_ENABLE, 8'h00, any_p2(), bad_pin(), 64'h0, wrong_sw(2'h2));
      send(INS_ENABLE, 8'h00, any_p2(), bad_pin(), 64'h0, wrong_sw(2'h1));
      send(INS_ENABLE, 8'h00, any_p2(), bad_pin(), 64'h0, wrong_sw(2'h0));
      check({15'h0, access_ok}, 16'h0);
      send(INS_ENABLE, 8'h00, any_p2(), cur_pin, 64'h0, SW_BLOCKED);
      send(INS_CHANGE, 8'h00, any_p2(), cur_pin, npin, SW_BLOCKED);
      // Fresh store: three wrong changes block, then disable refused
      do_reset();
      send(INS_CHANGE, 8'h00, any_p2(), bad_pin(), npin, wrong_sw(2'h2));
      send(INS_CHANGE, 8'h00, any_p2(), bad_pin(), npin, wrong_sw(2'h1));
      send(INS_CHANGE, 8'h00, any_p2(), bad_pin(), npin, wrong_sw(2'h0));
      send(INS_DISABLE, 8'h00, any_p2(), cur_pin, 64'h0, SW_BLOCKED);
      check({15'h0, access_ok}, 16'h0);
      finish_test();
   end
endmodule // pin_change_disable_enable_tb

// File: test/pin_link_monitor.sv
// Checker: timing and meaning of the PIN command link between both ends
`timescale 1ns/100ps
module pin_link_monitor
   import pin_cmd_pkg::*;
(
   // Clock and reset
   input wire logic         clock,
   input wire logic         reset,
   // Link signals
   input wire logic         cmd_valid,
   input wire logic [7:0]   ins,
   input wire logic [7:0]   p1,
   input wire logic [7:0]   p2,
   input wire logic [7:0]   lc,
   input wire logic [127:0] data,
   input wire logic         rsp_valid,
   input wire logic [15:0]  sw,
   // Card user side
   input wire logic         busy,
   input wire logic         access_ok,
   input wire logic         alt_key_needed
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   // ==========================================================
   // Helper: command code is one of the three handled
   logic known; // Decoded from the held instruction
   assign known = (ins == INS_CHANGE) || (ins == INS_DISABLE) || (ins == INS_ENABLE);
   // ==========================================================
   // Assertions
   a_unknown_refused: assert property (cmd_valid && !busy && !known |->
      ##2 rsp_valid && sw == SW_INS)
      else $error("unknown command not refused in two cycles");
   a_busy_marks: assert property (cmd_valid && !busy |=> busy)
      else $error("card not busy after taking a command");
   // Commit must finish inside the fixed window, never in the first cycle
   a_answer_bound: assert property (cmd_valid && !busy |=> !rsp_valid ##[1:10] rsp_valid)
      else $error("response outside its window");
   a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
      else $error("response valid longer than one cycle");
   a_sw_held: assert property (!rsp_valid |-> $stable(sw))
      else $error("status word moved without a response");
   a_fields_held: assert property (!cmd_valid |-> $stable({ins, p1, p2, lc, data}))
      else $error("command fields moved between commands");
   a_lc_fixed: assert property (cmd_valid && known |->
      lc == ((ins == INS_CHANGE) ? LC_CHANGE : LC_SINGLE))
      else $error("length byte wrong for command");
   a_p1_plain: assert property (cmd_valid && known && ins != INS_DISABLE |-> p1 == P1_PLAIN)
      else $error("option byte not zero");
   a_retry_code: assert property (rsp_valid && sw[15:4] == SW_WRONG[15:4] |->
      sw[3:0] < 4'h3)
      else $error("retry count above initial value");
   a_block_shuts: assert property (rsp_valid && sw == SW_WRONG |-> ##2 !access_ok)
      else $error("blocked PIN still grants access");
   a_disable_opens: assert property (rsp_valid && sw == SW_OK && ins == INS_DISABLE &&
      !p1[P_SEL_BIT] |-> ##2 access_ok && !alt_key_needed)
      else $error("plain disable did not open access");
   a_replace_needs: assert property (rsp_valid && sw == SW_OK && ins == INS_DISABLE &&
      p1[P_SEL_BIT] |-> ##2 alt_key_needed)
      else $error("replacement key not put in use");
   a_enable_closes: assert property (rsp_valid && sw == SW_OK && ins == INS_ENABLE |->
      ##2 !access_ok && !alt_key_needed)
      else $error("enable left access open");
   // ==========================================================
   // Coverage of main scenarios
   c_blocked: cover property (rsp_valid && sw == SW_BLOCKED);
   c_replace: cover property (rsp_valid && sw == SW_OK && ins == INS_DISABLE && p1[P_SEL_BIT]);
   c_change_ok: cover property (rsp_valid && sw == SW_OK && ins == INS_CHANGE);
endmodule // pin_link_monitor

// File: verilog/pin_card_end.sv
// Card end: change, disable and enable PIN command interpreter
`timescale 1ns/100ps
// Function
// - Change only when PIN enabled, not blocked
// - Good change: retries to 3, store new PIN
// - Bad change: decrement retries, keep PIN
// - Three failures persistently block the PIN
// - Terminal sends change P1 00, Lc 10
// - Old PIN bytes 1-8, new 9-16
// - Refuse disable when disabled or blocked
// - Good disable: retries to 3, disable
// - Bad disable: decrement, stays enabled
// - Disabled without replacement grants access
// - Replacement sets alternative key qualifier 08
// - Multi-reference files open once one disabled
// - Disable P1: b8 replace, b7-b6 zero, reference
// - Disable and enable send Lc 08
// - Refuse enable when enabled or blocked
// - Good enable: retries to 3, enable
// - Re-enable writes qualifier 00
// - Bad enable: decrement, stays disabled
// - Third bad enable blocks, may enable
// - Blocked disabled stays granted, enabled not
// - P2 b8 scope, b7-b6 zero, reference
module pin_card_end
   import pin_cmd_pkg::*;
(
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        reset,
   // Link to terminal
   pin_link_if.card         link,
   // Access evaluation, user side
   input  wire logic        multi_ref,      // File names several key references
   output logic             access_ok,      // Access condition met
   output logic             alt_key_needed, // Alternative key must be verified
   output logic             busy            // Command in progress
);
   typedef enum logic [2:0] {
      S_IDLE   = 3'b001,   // Wait for command
      S_COMMIT = 3'b010,   // Non-volatile write under way
      S_RESP   = 3'b100    // Return status
   } state_t;

   state_t      state;          // Sequencer state
   state_t      next_state;
   logic [15:0] sw_hold;        // Status to return
   logic [15:0] next_sw_hold;
   logic        rsp_valid_q;    // Response strobe
   logic        next_rsp_valid;
   logic [15:0] sw_q;           // Response status word
   logic [15:0] next_sw_q;
   logic        next_access_ok;
   logic        next_alt_key;
   logic        next_busy;
   // Commit request towards the store
   logic        wr_req;
   logic [63:0] wr_pin;
   logic [1:0]  wr_retry;
   logic        wr_enabled;
   logic        wr_blocked;
   logic [7:0]  wr_qual;
   logic        wr_done;
   // Stored state
   logic [63:0] pin;
   logic [1:0]  retry;
   logic        enabled;
   logic        blocked;
   logic [7:0]  qual;
   // Decode helpers
   logic        p2_ok;
   logic        p1_dis_ok;
   logic        pin_match;
   logic [63:0] presented;
   logic [1:0]  dec_retry;

   // ==========================================================
   // Persistent store
   pin_nv_store nv (
      .clock      (clock),
      .reset      (reset),
      .wr_req     (wr_req),
      .wr_pin     (wr_pin),
      .wr_retry   (wr_retry),
      .wr_enabled (wr_enabled),
      .wr_blocked (wr_blocked),
      .wr_qual    (wr_qual),
      .wr_done    (wr_done),
      .pin        (pin),
      .retry      (retry),
      .enabled    (enabled),
      .blocked    (blocked),
      .qual       (qual)
   );

   // ==========================================================
   // Header checks and PIN compare
   always_comb begin
      // Reference nonzero, reserved bits clear
      p2_ok     = (link.p2[6:5] == 2'b00) && (link.p2[P_REF_HI:0] != 5'h00);
      // Plain code, or replacement with a valid key number
      p1_dis_ok = (link.p1 == P1_PLAIN) ||
                  (link.p1[P_SEL_BIT] && (link.p1[6:5] == 2'b00) &&
                   (link.p1[P_REF_HI:0] != 5'h00));
      presented = link.data[127:64];
      pin_match = (presented == pin);
      dec_retry = (retry == 2'h0) ? 2'h0 : retry - 2'h1;
   end

   // ==========================================================
   // Command sequencer
   always_comb begin
      next_state     = state;
      next_sw_hold   = sw_hold;
      next_rsp_valid = 1'b0;
      next_sw_q      = sw_q;
      wr_req         = 1'b0;
      wr_pin         = pin;
      wr_retry       = retry;
      wr_enabled     = enabled;
      wr_blocked     = blocked;
      wr_qual        = qual;
      unique case (state)
         S_IDLE: begin
            if (link.cmd_valid) begin
               next_state = S_RESP;   // Refusals answer without a commit
               if (link.ins != INS_CHANGE && link.ins != INS_DISABLE &&
                   link.ins != INS_ENABLE) begin
                  next_sw_hold = SW_INS;
               end else if (!p2_ok || (link.ins != INS_DISABLE && link.p1 != P1_PLAIN)
                            || (link.ins == INS_DISABLE && !p1_dis_ok)) begin
                  next_sw_hold = SW_P1P2;
               end else if (link.lc != ((link.ins == INS_CHANGE) ? LC_CHANGE : LC_SINGLE)) begin
                  next_sw_hold = SW_LEN;
               end else if (blocked) begin
                  next_sw_hold = SW_BLOCKED;
               end else if ((link.ins == INS_ENABLE) == enabled) begin
                  next_sw_hold = SW_STATE;
               end else begin
                  wr_req     = 1'b1;
                  next_state = S_COMMIT;
                  if (pin_match) begin
                     next_sw_hold = SW_OK;
                     wr_retry     = RETRY_INIT;
                     if (link.ins == INS_CHANGE) begin
                        wr_pin = link.data[63:0];
                     end else if (link.ins == INS_DISABLE) begin
                        wr_enabled = 1'b0;
                        wr_qual = link.p1[P_SEL_BIT] ? QUAL_USE : QUAL_NONE;
                     end else begin
                        wr_enabled = 1'b1;
                        wr_qual    = QUAL_NONE;
                     end
                  end else begin
                     // Decrement, stored PIN kept; at zero block the PIN, and a bad enable also sets enabled
                     wr_retry     = dec_retry;
                     next_sw_hold = {SW_WRONG[15:4], 2'b00, dec_retry};
                     if (dec_retry == 2'h0) begin
                        wr_blocked = 1'b1;
                        if (link.ins == INS_ENABLE) begin
                           wr_enabled = BLOCK_ENABLES;
                        end
                     end
                  end
               end
            end
         end
         S_COMMIT: begin
            if (wr_done) begin
               next_state = S_RESP;
            end
         end
         S_RESP: begin
            next_rsp_valid = 1'b1;
            next_sw_q      = sw_hold;
            next_state     = S_IDLE;
         end
         default: begin
            next_state = S_IDLE;
         end
      endcase
   end

   // ==========================================================
   // Access evaluation from stored state
   always_comb begin
      next_busy      = (next_state != S_IDLE);
      next_alt_key   = !enabled && (qual == QUAL_USE) && !multi_ref;
      // Disabled PIN grants access unless the alternative key is needed, even when blocked
      // Multi-reference file opens once this one is off
      // Enabled and blocked never grants
      next_access_ok = !enabled && !next_alt_key;
   end

   // Registered outputs
   always_ff @(posedge clock) begin
      if (reset) begin
         state          <= S_IDLE;
         sw_hold        <= SW_OK;
         rsp_valid_q    <= 1'b0;
         sw_q           <= SW_OK;
         access_ok      <= 1'b0;
         alt_key_needed <= 1'b0;
         busy           <= 1'b0;
      end else begin
         state          <= next_state;
         sw_hold        <= next_sw_hold;
         rsp_valid_q    <= next_rsp_valid;
         sw_q           <= next_sw_q;
         access_ok      <= next_access_ok;
         alt_key_needed <= next_alt_key;
         busy           <= next_busy;
      end
   end

   assign link.rsp_valid = rsp_valid_q;
   assign link.sw        = sw_q;
endmodule // pin_card_end

// File: verilog/pin_cmd_pkg.sv
// Package: constants shared by the PIN management command ends
package pin_cmd_pkg;
   // ==========================================================
   // Command codes (instruction bytes)
   localparam logic [7:0] INS_CHANGE      = 8'h24;     // Change PIN
   localparam logic [7:0] INS_DISABLE     = 8'h26;     // Disable PIN
   localparam logic [7:0] INS_ENABLE      = 8'h28;     // Enable PIN
   // ==========================================================
   // Header field values
   localparam logic [7:0] P1_PLAIN        = 8'h00;     // Verification data only
   localparam logic [7:0] P1_RESERVED     = 8'h01;     // Reserved disable code
   localparam int         P_SEL_BIT       = 7;         // b8: replace / specific
   localparam int         P_REF_HI        = 4;         // Top of reference field
   localparam logic [7:0] LC_CHANGE       = 8'h10;     // Old plus new PIN
   localparam logic [7:0] LC_SINGLE       = 8'h08;     // One PIN
   localparam int         PIN_BYTES       = 8;         // Bytes per PIN value
   // ==========================================================
   // Reset and qualifier values
   localparam logic [1:0] RETRY_INIT      = 2'h3;      // Attempts after success
   localparam logic [7:0] QUAL_USE        = 8'h08;     // Alternative key in use
   localparam logic [7:0] QUAL_NONE       = 8'h00;     // Alternative key unused
   localparam logic [63:0] PIN_INIT       = 64'h3132333435363738; // Arbitrary
   localparam logic       BLOCK_ENABLES   = 1'b1;      // Blocked enable sets on
   // ==========================================================
   // Status words
   localparam logic [15:0] SW_OK          = 16'h9000;  // Success
   localparam logic [15:0] SW_WRONG       = 16'h63c0;  // Low nibble = retries
   localparam logic [15:0] SW_BLOCKED     = 16'h6983;  // PIN blocked
   localparam logic [15:0] SW_STATE       = 16'h6985;  // Already in that state
   localparam logic [15:0] SW_LEN         = 16'h6700;  // Wrong Lc
   localparam logic [15:0] SW_P1P2        = 16'h6b00;  // Wrong P1/P2
   localparam logic [15:0] SW_INS         = 16'h6d00;  // Unknown command
   // ==========================================================
   // Timing: non-volatile commit time
   localparam int         NV_WRITE_NS     = 200;       // Commit time in ns
   localparam int         CLK_NS          = 25;        // Clock period
   localparam int         NV_CYCLES       = (NV_WRITE_NS + CLK_NS - 1) / CLK_NS;
endpackage

// File: verilog/pin_link_if.sv
// Interface: command/response link between terminal end and card end
`timescale 1ns/100ps
interface pin_link_if;
   logic       cmd_valid;   // Terminal: header and data valid (pulse)
   logic [7:0] ins;         // Instruction
   logic [7:0] p1;          // Parameter 1
   logic [7:0] p2;          // Parameter 2, PIN reference
   logic [7:0] lc;          // Data length
   logic [127:0] data;      // Data bytes, byte 1 in bits 127:120
   logic       rsp_valid;   // Card: status word valid (pulse)
   logic [15:0] sw;         // Status word
   modport card (input cmd_valid, ins, p1, p2, lc, data, output rsp_valid, sw);
   modport terminal (output cmd_valid, ins, p1, p2, lc, data, input rsp_valid, sw);
endinterface

// File: verilog/pin_nv_store.sv
// Non-volatile store model: PIN, retry count, flags, committed atomically
`timescale 1ns/100ps
module pin_nv_store
   import pin_cmd_pkg::*;
(
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        reset,
   // Commit request
   input  wire logic        wr_req,
   input  wire logic [63:0] wr_pin,
   input  wire logic [1:0]  wr_retry,
   input  wire logic        wr_enabled,
   input  wire logic        wr_blocked,
   input  wire logic [7:0]  wr_qual,
   output logic             wr_done,
   // Stored state
   output logic [63:0]      pin,
   output logic [1:0]       retry,
   output logic             enabled,
   output logic             blocked,
   output logic [7:0]       qual
);
   logic [7:0] busy_cnt;        // Cycles left in commit
   logic [7:0] next_busy_cnt;
   logic       next_wr_done;
   logic        capture;        // Request taken into the hold copy
   logic [63:0] hold_pin;       // Fields held until the commit lands
   logic [1:0]  hold_retry;
   logic        hold_enabled;
   logic        hold_blocked;
   logic [7:0]  hold_qual;
   // ==========================================================
   // Commit timer: all fields land together on the last cycle
   always_comb begin
      next_busy_cnt = busy_cnt;
      next_wr_done  = 1'b0;
      capture       = 1'b0;
      if (busy_cnt != 8'h00) begin
         next_busy_cnt = busy_cnt - 8'h01;
         if (busy_cnt == 8'h01) begin
            next_wr_done = 1'b1;
         end
      end else if (wr_req) begin
         // Requester shows its fields only now, so copy them here
         capture       = 1'b1;
         next_busy_cnt = 8'(NV_CYCLES);
      end
   end
   // Stored fields survive sessions; reset stands for first power-up only
   always_ff @(posedge clock) begin
      if (reset) begin
         busy_cnt <= 8'h00;
         wr_done  <= 1'b0;
         pin      <= PIN_INIT;
         retry    <= RETRY_INIT;
         enabled  <= 1'b1;
         blocked  <= 1'b0;
         qual     <= QUAL_NONE;
         hold_pin     <= PIN_INIT;
         hold_retry   <= RETRY_INIT;
         hold_enabled <= 1'b1;
         hold_blocked <= 1'b0;
         hold_qual    <= QUAL_NONE;
      end else begin
         busy_cnt <= next_busy_cnt;
         wr_done  <= next_wr_done;
         if (capture) begin
            hold_pin     <= wr_pin;
            hold_retry   <= wr_retry;
            hold_enabled <= wr_enabled;
            hold_blocked <= wr_blocked;
            hold_qual    <= wr_qual;
         end
         if (next_wr_done) begin
            pin     <= hold_pin;
            retry   <= hold_retry;
            enabled <= hold_enabled;
            blocked <= hold_blocked;
            qual    <= hold_qual;
         end
      end
   end
endmodule // pin_nv_store

// File: verilog/pin_terminal_end.sv
// Terminal end: builds change, disable and enable PIN commands
`timescale 1ns/100ps
module pin_terminal_end
   import pin_cmd_pkg::*;
(
   // Clock and reset
   input  wire logic         clock,
   input  wire logic         reset,
   // User request
   input  wire logic         req_valid,  // Pulse: issue a command
   input  wire logic [7:0]   req_ins,    // Which command
   input  wire logic [7:0]   req_p1,     // Disable option byte
   input  wire logic [7:0]   req_p2,     // PIN reference
   input  wire logic [63:0]  req_pin,    // PIN or old PIN
   input  wire logic [63:0]  req_new,    // New PIN for change
   output logic              req_ready,  // No command outstanding
   output logic              done,       // Pulse: status arrived
   output logic [15:0]       status,     // Last status word
   // Link to card
   pin_link_if.terminal      link
);
   logic         cmd_valid_q;            // Command strobe
   logic [7:0]   ins_q, p1_q, p2_q, lc_q;
   logic [127:0] data_q;
   logic         pending;                // Awaiting response
   logic         next_pending;
   logic         go;
   // ==========================================================
   // Command framing: P1 fixed except for disable, Lc by command
   always_comb begin
      go           = req_valid && !pending;
      next_pending = go ? 1'b1 : (link.rsp_valid ? 1'b0 : pending);
   end
   always_ff @(posedge clock) begin
      if (reset) begin
         cmd_valid_q <= 1'b0;
         ins_q       <= 8'h00;
         p1_q        <= 8'h00;
         p2_q        <= 8'h00;
         lc_q        <= 8'h00;
         data_q      <= '0;
         pending     <= 1'b0;
         req_ready   <= 1'b0;
         done        <= 1'b0;
         status      <= 16'h0000;
      end else begin
         cmd_valid_q <= go;
         pending     <= next_pending;
         req_ready   <= !next_pending;
         done        <= link.rsp_valid;
         if (link.rsp_valid) begin
            status <= link.sw;
         end
         if (go) begin
            ins_q  <= req_ins;
            p1_q   <= (req_ins == INS_DISABLE) ? req_p1 : P1_PLAIN;
            p2_q   <= req_p2;
            lc_q   <= (req_ins == INS_CHANGE) ? LC_CHANGE : LC_SINGLE;
            data_q <= {req_pin, (req_ins == INS_CHANGE) ? req_new : 64'h0};
         end
      end
   end
   assign link.cmd_valid = cmd_valid_q;
   assign link.ins       = ins_q;
   assign link.p1        = p1_q;
   assign link.p2        = p2_q;
   assign link.lc        = lc_q;
   assign link.data      = data_q;
endmodule // pin_terminal_end
